// *** verilog/csbu_top.v ***
// compare, skip and branch unit of an 8-bit core, reached over axi4-lite
// assumes one 200 mhz clock and a synchronous active-low reset
//
// Summary of operation
// - compare immediate sets six flags, one cycle
// - register bit clear skips next, flags kept
// - register bit set skips next instruction
// - io bit clear skips next, 1 to 3 cycles
// - io bit set skips next, flags kept
// - flag set branch jumps pc plus k plus one
// - flag clear branch jumps, else falls through
// - equal branch jumps when zero flag set
// - not equal branch jumps when zero clear
// - same or higher branch jumps when carry clear
// - minus branch jumps when negative flag set
`timescale 1ns/10ps
`include "csbu_defines.vh"

module csbu_top (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // write address channel
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // execution state
  output wire busy
);

  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // merge write data into an old word by byte strobes
  function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] strb;
    integer i;
    begin
      merge_bytes = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction
  // pick one bit of a byte
  function pick_bit;
    input [7:0] value;
    input [2:0] sel;
    begin
      pick_bit = value[sel];
    end
  endfunction
  // sign extend a 7-bit offset to program counter width
  function [15:0] sext_k;
    input [6:0] k;
    begin
      sext_k = {{9{k[6]}}, k};
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg [`CSBU_INSTR_W-1:0] instr_reg;
  reg [`CSBU_OPER_W-1:0] oper_reg;
  reg [15:0] pc_reg;
  reg [7:0] sr_reg;
  reg state_reg;
  reg [1:0] cnt_reg;
  reg taken_reg;
  reg illegal_reg;
  reg [1:0] cyc_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [`CSBU_ADDR_MSB:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  ////////////////////////////////////////////////////////////////////////////
  // decode of the current instruction
  wire [3:0] op = instr_reg[`CSBU_F_OP];
  wire [2:0] bsel = instr_reg[`CSBU_F_BIT];
  wire [6:0] koff = instr_reg[`CSBU_F_K];
  wire [7:0] rd = oper_reg[`CSBU_F_REG];
  wire [7:0] imm = oper_reg[`CSBU_F_IMM];
  wire [7:0] iov = oper_reg[`CSBU_F_IO];
  wire next_long = oper_reg[`CSBU_F_LONG];
  // compare difference and flags, difference itself is discarded
  wire [7:0] diff = rd - imm;
  wire cmp_h = (~rd[3] & imm[3]) | (imm[3] & diff[3]) | (diff[3] & ~rd[3]);
  wire cmp_v = (rd[7] & ~imm[7] & ~diff[7]) | (~rd[7] & imm[7] & diff[7]);
  wire cmp_n = diff[7];
  wire cmp_z = (diff == 8'h00);
  wire cmp_c = (~rd[7] & imm[7]) | (imm[7] & diff[7]) | (diff[7] & ~rd[7]);
  reg is_skip;
  reg is_branch;
  reg cond;
  reg legal;
  reg [1:0] cyc_need;
  reg [15:0] pc_new;
  reg [7:0] sr_new;
  always @* begin
    is_skip = 1'b0;
    is_branch = 1'b0;
    cond = 1'b0;
    legal = 1'b1;
    case (op)
      `CSBU_OP_CMP_IMM: begin
        cond = 1'b0;
      end
      `CSBU_OP_SKIP_REG_CLR: begin
        is_skip = 1'b1;
        cond = ~pick_bit(rd, bsel);
      end
      `CSBU_OP_SKIP_REG_SET: begin
        is_skip = 1'b1;
        cond = pick_bit(rd, bsel);
      end
      `CSBU_OP_SKIP_IO_CLR: begin
        is_skip = 1'b1;
        cond = ~pick_bit(iov, bsel);
      end
      `CSBU_OP_SKIP_IO_SET: begin
        is_skip = 1'b1;
        cond = pick_bit(iov, bsel);
      end
      `CSBU_OP_BR_FLAG_SET: begin
        is_branch = 1'b1;
        cond = pick_bit(sr_reg, bsel);
      end
      `CSBU_OP_BR_FLAG_CLR: begin
        is_branch = 1'b1;
        cond = ~pick_bit(sr_reg, bsel);
      end
      `CSBU_OP_BR_EQUAL: begin
        is_branch = 1'b1;
        cond = sr_reg[`CSBU_SR_Z];
      end
      `CSBU_OP_BR_NOT_EQUAL: begin
        is_branch = 1'b1;
        cond = ~sr_reg[`CSBU_SR_Z];
      end
      `CSBU_OP_BR_SAME_HIGHER: begin
        is_branch = 1'b1;
        cond = ~sr_reg[`CSBU_SR_C];
      end
      `CSBU_OP_BR_MINUS: begin
        is_branch = 1'b1;
        cond = sr_reg[`CSBU_SR_N];
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // outcome: new program counter, new flags, cycles needed
  always @* begin
    pc_new = pc_reg + `CSBU_PC_STEP1;
    sr_new = sr_reg;
    cyc_need = `CSBU_CYC_ONE;
    if (legal && (op == `CSBU_OP_CMP_IMM)) begin
      sr_new[`CSBU_SR_H] = cmp_h;
      sr_new[`CSBU_SR_V] = cmp_v;
      sr_new[`CSBU_SR_N] = cmp_n;
      sr_new[`CSBU_SR_Z] = cmp_z;
      sr_new[`CSBU_SR_C] = cmp_c;
      sr_new[`CSBU_SR_S] = cmp_n ^ cmp_v;
    end else if (is_skip && cond) begin
      // skip over a one- or two-word follower
      if (next_long) begin
        pc_new = pc_reg + `CSBU_PC_STEP3;
        cyc_need = `CSBU_CYC_THREE;
      end else begin
        pc_new = pc_reg + `CSBU_PC_STEP2;
        cyc_need = `CSBU_CYC_TWO;
      end
    end else if (is_branch && cond) begin
      pc_new = pc_reg + sext_k(koff) + `CSBU_PC_STEP1;
      cyc_need = `CSBU_CYC_TWO;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus write path
  wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire wr_hit = (waddr_reg == `CSBU_ADDR_INSTR) | (waddr_reg == `CSBU_ADDR_OPER) |
                (waddr_reg == `CSBU_ADDR_PC) | (waddr_reg == `CSBU_ADDR_STAT) |
                (waddr_reg == `CSBU_ADDR_RESULT);
  wire wr_ok = wr_fire & wr_hit & (state_reg == ST_IDLE) &
               (waddr_reg != `CSBU_ADDR_RESULT);
  wire exec_done = (state_reg == ST_EXEC) & ((cnt_reg + `CSBU_CYC_ONE) == cyc_need);
  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
  assign busy = (state_reg == ST_EXEC);
  always @(posedge ref_clk) begin
    if (!resetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSBU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        waddr_reg <= {s_axi_awaddr[`CSBU_ADDR_MSB:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (!wr_hit) begin
          s_axi_bresp <= `CSBU_RESP_DECERR;
        end else if (!wr_ok) begin
          s_axi_bresp <= `CSBU_RESP_SLVERR;
        end else begin
          s_axi_bresp <= `CSBU_RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers and execution sequencer
  wire [31:0] instr_word = {{(32-`CSBU_INSTR_W){1'b0}}, instr_reg};
  wire [31:0] oper_word = {{(32-`CSBU_OPER_W){1'b0}}, oper_reg};
  wire [31:0] instr_m = merge_bytes(instr_word, wdata_reg, wstrb_reg);
  wire [31:0] oper_m = merge_bytes(oper_word, wdata_reg, wstrb_reg);
  wire [31:0] pc_m = merge_bytes({16'h0000, pc_reg}, wdata_reg, wstrb_reg);
  wire [31:0] sr_m = merge_bytes({24'h000000, sr_reg}, wdata_reg, wstrb_reg);
  always @(posedge ref_clk) begin
    if (!resetn) begin
      instr_reg <= `CSBU_INSTR_RST;
      oper_reg <= `CSBU_OPER_RST;
      pc_reg <= `CSBU_PC_RST;
      sr_reg <= `CSBU_SR_RST;
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      taken_reg <= 1'b0;
      illegal_reg <= 1'b0;
      cyc_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_ok) begin
            case (waddr_reg)
              `CSBU_ADDR_INSTR: begin
                // a write here launches execution
                instr_reg <= instr_m[`CSBU_INSTR_W-1:0];
                state_reg <= ST_EXEC;
                cnt_reg <= 2'h0;
              end
              `CSBU_ADDR_OPER: begin
                oper_reg <= oper_m[`CSBU_OPER_W-1:0];
              end
              `CSBU_ADDR_PC: begin
                pc_reg <= pc_m[15:0];
              end
              `CSBU_ADDR_STAT: begin
                sr_reg <= sr_m[7:0];
              end
              default: begin
              end
            endcase
          end
        end
        ST_EXEC: begin
          if (exec_done) begin
            // commit at the last cycle of the instruction
            pc_reg <= pc_new;
            sr_reg <= sr_new;
            taken_reg <= cond & (is_skip | is_branch);
            illegal_reg <= ~legal;
            cyc_reg <= cyc_need;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + `CSBU_CYC_ONE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus read path
  assign s_axi_arready = ~s_axi_rvalid;
  wire [`CSBU_ADDR_MSB:0] raddr = {s_axi_araddr[`CSBU_ADDR_MSB:2], 2'b00};
  reg [31:0] rd_word;
  reg rd_hit;

  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (raddr)
      `CSBU_ADDR_INSTR: begin
        rd_word = instr_word;
      end
      `CSBU_ADDR_OPER: begin
        rd_word = oper_word;
      end
      `CSBU_ADDR_PC: begin
        rd_word = {16'h0000, pc_reg};
      end
      `CSBU_ADDR_STAT: begin
        rd_word = {24'h000000, sr_reg};
      end
      `CSBU_ADDR_RESULT: begin
        rd_word[`CSBU_RES_BUSY] = busy;
        rd_word[`CSBU_RES_TAKEN] = taken_reg;
        rd_word[`CSBU_RES_ILLEGAL] = illegal_reg;
        rd_word[`CSBU_F_RES_CYC] = cyc_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CSBU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `CSBU_RESP_OKAY : `CSBU_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // csbu_top

// *** verilog/csbu_defines.vh ***
// constants for the compare, skip and branch unit
// assumes inclusion by bare name from the design file
`ifndef CSBU_DEFINES_VH
`define CSBU_DEFINES_VH

// register byte offsets
`define CSBU_ADDR_INSTR 8'h00
`define CSBU_ADDR_OPER 8'h04
`define CSBU_ADDR_PC 8'h08
`define CSBU_ADDR_STAT 8'h0c
`define CSBU_ADDR_RESULT 8'h10
`define CSBU_ADDR_MSB 7

// instruction word fields
`define CSBU_F_OP 3:0
`define CSBU_F_BIT 6:4
`define CSBU_F_K 13:7
`define CSBU_INSTR_W 14

// operand word fields
`define CSBU_F_REG 7:0
`define CSBU_F_IMM 15:8
`define CSBU_F_IO 23:16
`define CSBU_F_LONG 24
`define CSBU_OPER_W 25

// operation codes
`define CSBU_OP_CMP_IMM 4'h0
`define CSBU_OP_SKIP_REG_CLR 4'h1
`define CSBU_OP_SKIP_REG_SET 4'h2
`define CSBU_OP_SKIP_IO_CLR 4'h3
`define CSBU_OP_SKIP_IO_SET 4'h4
`define CSBU_OP_BR_FLAG_SET 4'h5
`define CSBU_OP_BR_FLAG_CLR 4'h6
`define CSBU_OP_BR_EQUAL 4'h7
`define CSBU_OP_BR_NOT_EQUAL 4'h8
`define CSBU_OP_BR_SAME_HIGHER 4'h9
`define CSBU_OP_BR_MINUS 4'ha

// status register bit positions
`define CSBU_SR_C 0
`define CSBU_SR_Z 1
`define CSBU_SR_N 2
`define CSBU_SR_V 3
`define CSBU_SR_S 4
`define CSBU_SR_H 5

// result word fields
`define CSBU_RES_BUSY 0
`define CSBU_RES_TAKEN 1
`define CSBU_RES_ILLEGAL 2
`define CSBU_F_RES_CYC 5:4

// cycle counts and program counter steps
`define CSBU_CYC_ONE 2'h1
`define CSBU_CYC_TWO 2'h2
`define CSBU_CYC_THREE 2'h3
`define CSBU_PC_STEP1 16'h0001
`define CSBU_PC_STEP2 16'h0002
`define CSBU_PC_STEP3 16'h0003

// reset values
`define CSBU_PC_RST 16'h0000
`define CSBU_SR_RST 8'h00
`define CSBU_INSTR_RST 14'h0000
`define CSBU_OPER_RST 25'h0000000

// bus responses
`define CSBU_RESP_OKAY 2'h0
`define CSBU_RESP_SLVERR 2'h2
`define CSBU_RESP_DECERR 2'h3

`endif

// *** sim/csbu_top_asserts.sv ***
// checker for the compare, skip and branch unit
// assumes binding to csbu_top, one clock, synchronous active-low reset
`timescale 1ns/10ps
`include "csbu_defines.vh"
module csbu_top_asserts (
  // clock and reset
  input logic ref_clk,
  input logic resetn,
  // write side
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  // read side
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // execution
  input logic busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_busy_end;
    ##[1:3] !busy;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted under pending response");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted under pending data");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_busy_span: assert property ($rose(busy) |-> s_busy_end)
    else $error("busy longer than three cycles");
  a_busy_start: assert property ($rose(busy) |-> s_axi_bvalid && s_axi_bresp == `CSBU_RESP_OKAY)
    else $error("busy without accepted write");
  a_busy_refuse: assert property ((s_wr_take ##1 busy) |=>
    s_axi_bvalid && s_axi_bresp == `CSBU_RESP_SLVERR)
    else $error("write during busy not refused");
endmodule // csbu_top_asserts

bind csbu_top csbu_top_asserts u_chk (.ref_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .busy);

// *** sim/tb_compare_skip_branch_unit.sv ***
// testbench for the compare, skip and branch unit
// assumes csbu_top with its defines header, bus driven at rising edges
`timescale 1ns/10ps
`include "csbu_defines.vh"
module tb_compare_skip_branch_unit;
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] b;
    logic [6:0] k;
    logic [24:0] opr;
    logic [7:0] st;
    logic [7:0] es;
    logic [15:0] epc;
    logic [5:0] er;
  } csbu_row_t;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer bad_count = 0;
  integer n_tests = 0;
  integer i;
  logic [31:0] d;
  logic [1:0] r;
  csbu_row_t rows [0:16];
  ////////////////////////////////////////////////////////////////////////////////
  csbu_top dut_u (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);
  always #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task axw(input [7:0] a, input [31:0] dv, input [3:0] s, output [1:0] rv);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= dv;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid === 1'b1));
    rv = s_axi_bresp;
  endtask
  task axr(input [7:0] a, output [31:0] dv, output [1:0] rv);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid === 1'b1));
    dv = s_axi_rdata;
    rv = s_axi_rresp;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_clear;
    for (int j = 0; j < 5; j++) begin
      axr(8'(j * 4), d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, `CSBU_RESP_OKAY});
    end
  endtask
  task wait_idle;
    d = 32'h1;
    for (i = 0; i < 8 && d[0] !== 1'b0; i++) axr(`CSBU_ADDR_RESULT, d, r);
  endtask
  task run_row(input csbu_row_t w);
    axw(`CSBU_ADDR_OPER, {7'h0, w.opr}, 4'hf, r);
    axw(`CSBU_ADDR_STAT, {24'h0, w.st}, 4'hf, r);
    axw(`CSBU_ADDR_PC, 32'h0100, 4'hf, r);
    axw(`CSBU_ADDR_INSTR, {18'h0, w.k, w.b, w.op}, 4'hf, r);
    chk({30'h0, r}, {30'h0, `CSBU_RESP_OKAY});
    wait_idle();
    chk({26'h0, d[5:0]}, {26'h0, w.er});
    axr(`CSBU_ADDR_PC, d, r);
    chk(d, 32'(w.epc));
    axr(`CSBU_ADDR_STAT, d, r);
    chk(d, {24'h0, w.es});
  endtask
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    rows = '{'{4'h0,3'h0,7'h00,25'h0002010,8'h00,8'h15,16'h0101,6'h10},
      '{4'h0,3'h0,7'h00,25'h0008080,8'h00,8'h02,16'h0101,6'h10},
      '{4'h0,3'h0,7'h00,25'h0000180,8'h00,8'h38,16'h0101,6'h10},
      '{4'h1,3'h3,7'h00,25'h00000f7,8'h2a,8'h2a,16'h0102,6'h22},
      '{4'h1,3'h0,7'h00,25'h0000001,8'h2a,8'h2a,16'h0101,6'h10},
      '{4'h2,3'h7,7'h00,25'h1000080,8'h2a,8'h2a,16'h0103,6'h32},
      '{4'h3,3'h5,7'h00,25'h1df0000,8'h15,8'h15,16'h0103,6'h32},
      '{4'h4,3'h2,7'h00,25'h0040000,8'h15,8'h15,16'h0102,6'h22},
      '{4'h5,3'h5,7'h05,25'h0000000,8'h20,8'h20,16'h0106,6'h22},
      '{4'h6,3'h0,7'h05,25'h0000000,8'h01,8'h01,16'h0101,6'h10},
      '{4'h6,3'h3,7'h02,25'h0000000,8'h00,8'h00,16'h0103,6'h22},
      '{4'h7,3'h0,7'h7f,25'h0000000,8'h02,8'h02,16'h0100,6'h22},
      '{4'h8,3'h0,7'h05,25'h0000000,8'h02,8'h02,16'h0101,6'h10},
      '{4'h8,3'h0,7'h40,25'h0000000,8'h00,8'h00,16'h00c1,6'h22},
      '{4'h9,3'h0,7'h3f,25'h0000000,8'h00,8'h00,16'h0140,6'h22},
      '{4'ha,3'h0,7'h02,25'h0000000,8'h04,8'h04,16'h0103,6'h22},
      '{4'hb,3'h0,7'h00,25'h0000000,8'h00,8'h00,16'h0101,6'h14}};
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    // reset values of all five registers
    chk_clear();
    for (int j = 0; j < 17; j++) run_row(rows[j]);
    // byte strobes merge into the pc
    axw(`CSBU_ADDR_PC, 32'h1234, 4'hf, r);
    axw(`CSBU_ADDR_PC, 32'hffab, 4'h1, r);
    axr(`CSBU_ADDR_PC, d, r);
    chk(d, 32'h12ab);
    // three-cycle skip, pc write during it refused
    axw(`CSBU_ADDR_OPER, 32'h1000080, 4'hf, r);
    axw(`CSBU_ADDR_PC, 32'h0100, 4'hf, r);
    axw(`CSBU_ADDR_INSTR, {18'h0, 7'h00, 3'h7, `CSBU_OP_SKIP_REG_SET}, 4'hf, r);
    axw(`CSBU_ADDR_PC, 32'h0055, 4'hf, r);
    chk({30'h0, r}, {30'h0, `CSBU_RESP_SLVERR});
    wait_idle();
    axr(`CSBU_ADDR_PC, d, r);
    chk(d, 32'h0103);
    // result is read-only, unmapped offsets decode-error
    axw(`CSBU_ADDR_RESULT, 32'hff, 4'hf, r);
    chk({30'h0, r}, {30'h0, `CSBU_RESP_SLVERR});
    axw(8'h20, 32'h1, 4'hf, r);
    chk({30'h0, r}, {30'h0, `CSBU_RESP_DECERR});
    axr(8'h20, d, r);
    chk({30'h0, r}, {30'h0, `CSBU_RESP_DECERR});
    chk(d, 32'h0);
    // mid-run reset returns every register to zero
    axw(`CSBU_ADDR_PC, 32'h0077, 4'hf, r);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    chk_clear();
    close_out();
  end
endmodule // tb_compare_skip_branch_unit
